/* rtl/mrr_pkg.sv */
// package: offsets, field layouts, reset values, states and timing for the mode/supply registers
package mrr_pkg;

	// ------------------------------------------------------------
	// register selection (documented register port, 7-bit address)
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_MODE   = 7'h55; // device_mode_control address bits 15:9
	localparam logic [6:0] ADDR_SUPPLY = 7'h56; // supply_output_enables address bits 15:9

	// ------------------------------------------------------------
	// field positions within the 8-bit data byte
	// ------------------------------------------------------------
	localparam int BIT_KEEPALIVE  = 7; // keep-alive supply enable
	localparam int BIT_AUTO_WAKE  = 6; // sleep with automatic wake
	localparam int BIT_SLEEP_WAKE = 5; // sleep until wake event
	localparam int BIT_INT_REQ    = 4; // interrupt pulse request
	localparam int BIT_INIT       = 3; // readback: initialisation mode
	localparam int BIT_NORMAL     = 2; // readback: normal mode
	localparam int BIT_FAILSAFE_RES = 1; // readback: deep-failsafe resume
	localparam int BIT_LOWPWR_RES   = 0; // readback: low-power resume

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic       KEEPALIVE_RST = 1'h1; // part dependent; plain default
	localparam logic [3:0] SUPPLY_RST    = 4'hF; // all four supplies on
	localparam logic [3:0] SECURE_OFFSET = 4'h0; // security nibble sits in bits 3:0
	localparam logic [7:0] READBACK_RST  = 8'h00; // nothing read yet

	// ------------------------------------------------------------
	// supply enable field: write bits 7:4, read back in bits 3:0
	// ------------------------------------------------------------
	localparam int SUP_FIELD_LSB = 4; // lowest enable bit of a write
	localparam int SUP_COUNT     = 4; // number of supply enables
	localparam int SUP_CORE      = 3; // core supply within the nibble
	localparam int SUP_REF       = 2; // reference supply
	localparam int SUP_AUX       = 1; // auxiliary supply
	localparam int SUP_XCVR      = 0; // transceiver supply

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS    = 4000;    // 250 MHz
	localparam int AUTO_WAKE_US     = 1000;    // 1.0 ms auto-wake delay
	// picoseconds per microsecond over picoseconds per cycle
	localparam int AUTO_WAKE_CYCLES = (AUTO_WAKE_US * 1000000) / CLK_PERIOD_PS;
	localparam int INT_PULSE_CYCLES = 1;      // interrupt pulse length

	// ------------------------------------------------------------
	// low-power sequencer states; every step of both sleep paths flips one bit except MRR_LP_RESUM to MRR_LP_IDLE
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MRR_LP_IDLE  = 2'h0, // running
		MRR_LP_SLEEP = 2'h1, // low-power off, waiting for wake event
		MRR_LP_TIMED = 2'h2, // low-power off, timed auto-wake
		MRR_LP_RESUM = 2'h3  // leaving low-power off
	} mrr_lp_state_t;

	// ------------------------------------------------------------
	// register access carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic       valid; // one-cycle access strobe
		logic       write; // 1 write, 0 read
		logic [6:0] addr;  // register address
		logic [7:0] data;  // write data byte
	} mrr_access_t;

	// security nibble check: {~b5, ~b4, b7, b6}
	function automatic logic mrr_secure_ok(input logic [7:0] d);
		return d[3:0] == {~d[5], ~d[4], d[7], d[6]};
	endfunction

endpackage

/* rtl/mrr_regs.sv */
// module: mode control and supply enable registers with secured writes
module mrr_regs #(
	parameter int AUTO_WAKE_CYCLES = mrr_pkg::AUTO_WAKE_CYCLES
) (
	// clock and power-on reset
	input  wire logic                clk,
	input  wire logic                rst,
	// register access port
	input  wire mrr_pkg::mrr_access_t acc,
	output logic [7:0]               rd_data,
	// main state machine status
	input  wire logic                in_init_mode,
	input  wire logic                in_normal_mode,
	input  wire logic                deep_failsafe_resume,
	input  wire logic                wake_event,
	// outputs to the power stage
	output logic                     low_power_off,
	output logic                     int_pulse,
	output logic                     secure_error,
	output logic                     core_supply_on,
	output logic                     reference_supply_on,
	output logic                     auxiliary_supply_on,
	output logic                     transceiver_supply_on,
	output logic                     keepalive_supply_on
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mrr_pkg::mrr_lp_state_t lp_reg, lp_next; // low-power sequencer
	logic       auto_wake_sleep_request_reg, auto_wake_sleep_request_next;
	logic       sleep_until_wake_request_reg, sleep_until_wake_request_next;
	logic       int_req_reg, int_req_next;       // request bit as written
	logic       int_pulse_reg, int_pulse_next;   // outgoing pulse
	logic       fs_res_reg, fs_res_next;         // deep-failsafe resume flag
	logic       lpr_reg, lpr_next;               // low-power resume flag
	logic       sec_err_reg, sec_err_next;       // secured write error
	logic       keep_reg, keep_next;             // keep-alive enable
	logic [3:0] sup_reg, sup_next;               // core,ref,aux,xcvr
	logic [7:0] rd_reg, rd_next;                 // readback byte
	logic       timer_start;                     // arm timed wake
	logic       timer_done;                      // timed wake elapsed
	logic       lpo_reg, lpo_next;               // low-power off output

	// decoded accesses; the decode looks at the address, so an unmapped
	// address neither writes nor disturbs the readback byte
	logic       wr_mode;                         // write to the mode register
	logic       wr_sup;                          // write to the supply register
	logic       rd_mode;                         // read of the mode register
	logic       rd_sup;                          // read of the supply register
	logic       sec_ok;                          // security nibble matches data bits
	assign sec_ok  = mrr_pkg::mrr_secure_ok(acc.data);
	assign wr_mode = acc.valid && acc.write && acc.addr == mrr_pkg::ADDR_MODE;
	assign wr_sup  = acc.valid && acc.write && acc.addr == mrr_pkg::ADDR_SUPPLY;
	assign rd_mode = acc.valid && !acc.write && acc.addr == mrr_pkg::ADDR_MODE;
	assign rd_sup  = acc.valid && !acc.write && acc.addr == mrr_pkg::ADDR_SUPPLY;

	// ----------------------------------------------------------------
	// timed wake counter
	// ----------------------------------------------------------------
	// the long count sits in its own module so that it can be shortened
	// for simulation without touching the register logic
	mrr_wake_timer #(
		.CYCLES(AUTO_WAKE_CYCLES)
	) u_timer (
		.clk  (clk),
		.rst  (rst),
		.start(timer_start),
		.done (timer_done)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		lp_next                       = lp_reg;
		auto_wake_sleep_request_next  = auto_wake_sleep_request_reg;
		sleep_until_wake_request_next = sleep_until_wake_request_reg;
		int_req_next                  = int_req_reg;
		int_pulse_next                = 1'b0;
		fs_res_next                   = fs_res_reg;
		lpr_next                      = lpr_reg;
		sec_err_next                  = sec_err_reg;
		keep_next                     = keep_reg;
		sup_next                      = sup_reg;
		rd_next                       = rd_reg;
		timer_start                   = 1'b0;

		// ------------------------------------------------------------
		// register reads
		// ------------------------------------------------------------
		// mode register reads clear the resume flags; a same-cycle set wins below
		if (rd_mode) begin
			rd_next                            = mrr_pkg::READBACK_RST; // reserved bits read zero
			rd_next[mrr_pkg::BIT_KEEPALIVE]    = keep_reg;
			rd_next[mrr_pkg::BIT_INIT]         = in_init_mode;
			rd_next[mrr_pkg::BIT_NORMAL]       = in_normal_mode;
			rd_next[mrr_pkg::BIT_FAILSAFE_RES] = fs_res_reg;
			rd_next[mrr_pkg::BIT_LOWPWR_RES]   = lpr_reg;
			fs_res_next = 1'b0;
			lpr_next = 1'b0;
		end
		if (rd_sup)
			rd_next = {4'h0, sup_reg};

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		// writes only land with a valid security nibble (checked against bits 7:4);
		// the error flag is sticky here because its clear belongs to the
		// diagnostic register outside this block
		if ((wr_mode || wr_sup) && !sec_ok)
			sec_err_next = 1'b1;
		if (wr_mode && sec_ok) begin
			keep_next = acc.data[mrr_pkg::BIT_KEEPALIVE];
			int_req_next = acc.data[mrr_pkg::BIT_INT_REQ];
			if (acc.data[mrr_pkg::BIT_INT_REQ])
				int_pulse_next = 1'b1;
			// sleep only from running; auto-wake takes precedence if both set
			if (lp_reg == mrr_pkg::MRR_LP_IDLE) begin
				auto_wake_sleep_request_next  = acc.data[mrr_pkg::BIT_AUTO_WAKE];
				sleep_until_wake_request_next = acc.data[mrr_pkg::BIT_SLEEP_WAKE];
				if (acc.data[mrr_pkg::BIT_AUTO_WAKE]) begin
					lp_next     = mrr_pkg::MRR_LP_TIMED;
					timer_start = 1'b1;
				end else if (acc.data[mrr_pkg::BIT_SLEEP_WAKE]) begin
					lp_next = mrr_pkg::MRR_LP_SLEEP;
				end
			end
		end
		if (wr_sup && sec_ok)
			sup_next = acc.data[mrr_pkg::SUP_FIELD_LSB +: mrr_pkg::SUP_COUNT];

		// ------------------------------------------------------------
		// low-power sequencer
		// ------------------------------------------------------------
		case (lp_reg)
			mrr_pkg::MRR_LP_IDLE: begin
			end
			mrr_pkg::MRR_LP_SLEEP: begin
				if (wake_event)
					lp_next = mrr_pkg::MRR_LP_RESUM;
			end
			mrr_pkg::MRR_LP_TIMED: begin
				if (timer_done)
					lp_next = mrr_pkg::MRR_LP_RESUM;
			end
			mrr_pkg::MRR_LP_RESUM: begin
				auto_wake_sleep_request_next  = 1'b0;
				sleep_until_wake_request_next = 1'b0;
				lpr_next = 1'b1;
				lp_next  = mrr_pkg::MRR_LP_IDLE;
			end
			default: lp_next = mrr_pkg::MRR_LP_IDLE;
		endcase

		// set wins over read clear
		if (deep_failsafe_resume)
			fs_res_next = 1'b1;

		// the output is decoded from the next state so that it leaves a
		// flip-flop in the same cycle as the state itself
		lpo_next = lp_next == mrr_pkg::MRR_LP_SLEEP || lp_next == mrr_pkg::MRR_LP_TIMED;
	end

	// ----------------------------------------------------------------
	// registers; rst is the power-on reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			lp_reg                       <= mrr_pkg::MRR_LP_IDLE;
			auto_wake_sleep_request_reg  <= 1'b0;
			sleep_until_wake_request_reg <= 1'b0;
			int_req_reg                  <= 1'b0;
			int_pulse_reg                <= 1'b0;
			fs_res_reg                   <= 1'b0;
			lpo_reg                      <= 1'b0;
			lpr_reg                      <= 1'b0;
			sec_err_reg                  <= 1'b0;
			keep_reg                     <= mrr_pkg::KEEPALIVE_RST;
			sup_reg                      <= mrr_pkg::SUPPLY_RST;
			rd_reg                       <= mrr_pkg::READBACK_RST;
		end else begin
			lp_reg                       <= lp_next;
			auto_wake_sleep_request_reg  <= auto_wake_sleep_request_next;
			sleep_until_wake_request_reg <= sleep_until_wake_request_next;
			int_req_reg                  <= int_req_next;
			int_pulse_reg                <= int_pulse_next;
			fs_res_reg                   <= fs_res_next;
			lpo_reg                      <= lpo_next;
			lpr_reg                      <= lpr_next;
			sec_err_reg                  <= sec_err_next;
			keep_reg                     <= keep_next;
			sup_reg                      <= sup_next;
			rd_reg                       <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// supplies stay as programmed through low-power off; the power stage
	// decides what actually runs there
	assign rd_data               = rd_reg;
	assign low_power_off         = lpo_reg;
	assign int_pulse             = int_pulse_reg;
	assign secure_error          = sec_err_reg;
	assign core_supply_on        = sup_reg[mrr_pkg::SUP_CORE];
	assign reference_supply_on   = sup_reg[mrr_pkg::SUP_REF];
	assign auxiliary_supply_on   = sup_reg[mrr_pkg::SUP_AUX];
	assign transceiver_supply_on = sup_reg[mrr_pkg::SUP_XCVR];
	assign keepalive_supply_on   = keep_reg;
endmodule

/* rtl/mrr_wake_timer.sv */
// module: countdown timer that signals the end of the timed low-power period
module mrr_wake_timer #(
	parameter int CYCLES = mrr_pkg::AUTO_WAKE_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic start,
	output logic      done
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

	logic [W-1:0] cnt_reg;  // remaining cycles
	logic [W-1:0] cnt_next;
	logic         run_reg;  // counting
	logic         run_next;
	logic         done_reg; // expiry pulse
	logic         done_next;

	// ----------------------------------------------------------------
	// next count
	// ----------------------------------------------------------------
	always_comb begin
		cnt_next  = cnt_reg;
		run_next  = run_reg;
		done_next = 1'b0;
		if (start) begin
			cnt_next = LOAD;
			run_next = 1'b1;
		end else if (run_reg) begin
			if (cnt_reg == '0) begin
				run_next  = 1'b0;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg  <= '0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			run_reg  <= run_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
endmodule

/* verif/mrr_host_model.sv */
// host model: issues secured register accesses one at a time
module mrr_host_model (
	// clock
	input  wire logic            clk,
	// access port towards the registers
	output mrr_pkg::mrr_access_t acc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial acc = '0;
	// one strobe per call, launched and released on falling edges
	// supplies that this host treats as safety critical and never turns off;
	// none here, so every enable pattern stays reachable
	localparam logic [3:0] CRITICAL_SUPPLIES = 4'h0;
	task automatic access(input logic w, input logic [6:0] a, input logic [3:0] hi,
		input logic bad);
		logic [3:0] h; // upper bits as sent
		h = (w && a == mrr_pkg::ADDR_SUPPLY) ? (hi | CRITICAL_SUPPLIES) : hi;
		@(negedge clk);
		// nibble derived from the upper bits; bad flips its lowest bit on purpose
		acc <= {1'b1, w, a, h, ~h[1], ~h[0], h[3], h[2] ^ bad};
		@(negedge clk);
		acc <= '0;
	endtask
endmodule

/* verif/mrr_regs_checker.sv */
// checker: port-level properties of the mode and supply registers
module mrr_regs_checker #(
	parameter int AUTO_WAKE_CYCLES = 20
) (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// access port and readback
	input wire mrr_pkg::mrr_access_t acc,
	input wire logic [7:0]           rd_data,
	input wire logic                 in_init_mode,
	input wire logic                 in_normal_mode,
	// power stage outputs
	input wire logic                 low_power_off,
	input wire logic                 int_pulse,
	input wire logic                 secure_error,
	input wire logic                 core_supply_on,
	input wire logic                 reference_supply_on,
	input wire logic                 auxiliary_supply_on,
	input wire logic                 transceiver_supply_on,
	input wire logic                 keepalive_supply_on
);
	// ----------------------------------------
	// helper decode
	// ----------------------------------------
	localparam int AW_LO = AUTO_WAKE_CYCLES - 4; // slack for timer and resume steps
	localparam int AW_HI = AUTO_WAKE_CYCLES + 6;
	logic [3:0] sup; // supply enables from the output ports
	logic       ok;  // nibble matches upper bits
	logic       wm, ws, bad, rm, rs;
	assign sup = {core_supply_on, reference_supply_on, auxiliary_supply_on, transceiver_supply_on};
	assign ok  = acc.data[3:0] == {~acc.data[5], ~acc.data[4], acc.data[7], acc.data[6]};
	assign wm  = acc.valid & acc.write & ok & (acc.addr == mrr_pkg::ADDR_MODE);
	assign ws  = acc.valid & acc.write & ok & (acc.addr == mrr_pkg::ADDR_SUPPLY);
	assign bad = acc.valid & acc.write & ~ok
	           & ((acc.addr == mrr_pkg::ADDR_MODE) | (acc.addr == mrr_pkg::ADDR_SUPPLY));
	assign rm  = acc.valid & ~acc.write & (acc.addr == mrr_pkg::ADDR_MODE);
	assign rs  = acc.valid & ~acc.write & (acc.addr == mrr_pkg::ADDR_SUPPLY);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_supply_write: assert property (ws |=> sup == $past(acc.data[7:4]))
		else $error("supply enables differ from written byte");
	chk_bad_rejected: assert property (bad |=> $stable(sup) && $stable(keepalive_supply_on))
		else $error("rejected write changed an enable");
	chk_secure_flag: assert property (bad |=> secure_error)
		else $error("bad nibble did not raise the error flag");
	chk_int_pulse: assert property (wm && acc.data[4] |=> int_pulse ##1 !int_pulse)
		else $error("interrupt pulse missing or too long");
	chk_sleep_entry: assert property (wm && acc.data[5] && !low_power_off |=> low_power_off[*8])
		else $error("sleep request did not hold low power off");
	chk_auto_wake: assert property (wm && acc.data[6] && !low_power_off |=>
		low_power_off ##[AW_LO:AW_HI] $fell(low_power_off))
		else $error("auto wake came at the wrong time");
	chk_status_read: assert property (rm |=> rd_data[3:2] == $past({in_init_mode, in_normal_mode}))
		else $error("mode status bits do not follow the state machine");
	chk_mode_upper: assert property (rm |=> rd_data[7:4] == {keepalive_supply_on, 3'h0})
		else $error("mode upper read bits wrong");
	chk_supply_read: assert property (rs |=> rd_data == {4'h0, sup})
		else $error("supply readback wrong");
	chk_keep_write: assert property (wm |=> keepalive_supply_on == $past(acc.data[7]))
		else $error("keep-alive enable not written");
	cover property (wm && acc.data[6]);
	cover property (bad);
	cover property ($fell(low_power_off));
endmodule

bind mrr_regs mrr_regs_checker #(.AUTO_WAKE_CYCLES(AUTO_WAKE_CYCLES)) u_chk (.clk, .rst, .acc,
	.rd_data, .in_init_mode, .in_normal_mode, .low_power_off, .int_pulse, .secure_error,
	.core_supply_on, .reference_supply_on, .auxiliary_supply_on, .transceiver_supply_on,
	.keepalive_supply_on);

/* verif/mrr_regs_test.sv */
// testbench: directed and random register traffic through the host model
module mrr_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 20; // shortened auto-wake count
	localparam logic [6:0] AM = mrr_pkg::ADDR_MODE;
	localparam logic [6:0] AS = mrr_pkg::ADDR_SUPPLY;
	logic clk = 0, rst = 1, init_m = 1, norm_m = 0, fs_res = 0, wake = 0, pend = 0;
	logic [7:0]  rd_data, exp_q[$];
	logic        lpo, intp, serr, core, refs, aux, xcvr, keep;
	logic [3:0]  sup;
	logic [31:0] seed = 32'h9, v;
	int          miscompares = 0, checks = 0, cyc = 0, n;
	mrr_pkg::mrr_access_t acc;
	assign sup = {core, refs, aux, xcvr};
	always #2 clk = ~clk;
	mrr_host_model host (.clk(clk), .acc(acc));
	mrr_regs #(.AUTO_WAKE_CYCLES(AW)) DUT (.clk(clk), .rst(rst), .acc(acc), .rd_data(rd_data),
		.in_init_mode(init_m), .in_normal_mode(norm_m), .deep_failsafe_resume(fs_res),
		.wake_event(wake), .low_power_off(lpo), .int_pulse(intp), .secure_error(serr),
		.core_supply_on(core), .reference_supply_on(refs), .auxiliary_supply_on(aux),
		.transceiver_supply_on(xcvr), .keepalive_supply_on(keep));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// a read notes its expected byte; the monitor compares it
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 4'h0, 1'b0);
	endtask
	// ----------------------------------------
	// monitor and hang guard
	// ----------------------------------------
	always @(posedge clk) pend <= acc.valid & ~acc.write;
	always @(negedge clk) if (pend) check(rd_data, exp_q.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			stop_test;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) rst = 0;
		check({keep, lpo, intp, serr, sup}, 8'h8F);
		rd(AM, 8'h88);
		rd(AS, 8'h0F);
		for (n = 0; n < 6; n++) begin
			v = xs();
			host.access(1'b1, AS, v[3:0], 1'b0);
			check({4'h0, sup}, {4'h0, v[3:0]});
			rd(AS, {4'h0, v[3:0]});
		end
		// corrupted nibbles and an unmapped place change no enable; the bad nibbles set serr
		host.access(1'b1, AS, ~v[3:0], 1'b1);
		host.access(1'b1, AM, 4'h0, 1'b1);
		host.access(1'b1, 7'h10, 4'h0, 1'b0);
		check({serr, 2'h0, keep, sup}, {4'h9, v[3:0]});
		host.access(1'b1, AM, 4'h0, 1'b0);
		check({7'h0, keep}, 8'h00);
		host.access(1'b1, AM, 4'h8, 1'b0);
		init_m = 0;
		norm_m = 1;
		rd(AM, 8'h84);
		rd(7'h10, 8'h84);
		host.access(1'b1, AM, 4'h9, 1'b0);
		check({7'h0, intp}, 8'h01);
		@(negedge clk);
		check({7'h0, intp}, 8'h00);
		// sleep until a wake event
		host.access(1'b1, AM, 4'hA, 1'b0);
		repeat (30) @(negedge clk);
		check({7'h0, lpo}, 8'h01);
		wake = 1;
		@(negedge clk) wake = 0;
		for (n = 0; n < 10 && lpo !== 1'b0; n++) @(negedge clk);
		repeat (5) @(negedge clk);
		check({7'h0, lpo}, 8'h00);
		rd(AM, 8'h85);
		rd(AM, 8'h84);
		// timed sleep wakes by itself
		host.access(1'b1, AM, 4'hC, 1'b0);
		for (n = 0; n < AW + 20 && lpo === 1'b1; n++) @(negedge clk);
		check({7'h0, n >= AW && n <= AW + 6}, 8'h01);
		repeat (5) @(negedge clk);
		check({7'h0, lpo}, 8'h00);
		rd(AM, 8'h85);
		fs_res = 1;
		@(negedge clk) fs_res = 0;
		rd(AM, 8'h86);
		rd(AM, 8'h84);
		// second reset mid-run restores the enables
		host.access(1'b1, AS, 4'h0, 1'b0);
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		check({keep, lpo, intp, serr, sup}, 8'h8F);
		rd(AS, 8'h0F);
		repeat (3) @(negedge clk);
		stop_test;
	end
endmodule
